// >>> quad_conv_regs.vh
// Purpose: constants for the quad converter host controller
// Assumes: 50 MHz ref_clk (20 ns period)
// Notes: times in ns, cycle counts derived and rounded
`ifndef QUAD_CONV_REGS_VH
`define QUAD_CONV_REGS_VH
`define CLK_PERIOD_NS 20
`define CODE_WIDTH 12
`define CHAN_SEL_WIDTH 2
// Channel select codes: {high, low}
`define CHAN_A 2'b00
`define CHAN_B 2'b01
`define CHAN_C 2'b10
`define CHAN_D 2'b11
// Pin timing, least times in ns
`define T_READ_CS_NS 200
`define T_READ_SETUP_NS 10
`define T_DATA_VALID_NS 160
`define T_WRITE_CS_NS 50
`define T_LOAD_LOW_NS 50
`define T_LOAD_TO_CS_NS 70
`define T_LOAD_AFTER_CS_NS 50
`define T_BUS_RELEASE_NS 100
`define T_RESET_LOW_NS 50
// Cycle counts, rounded up, at least one
`define CYC(ns) ((((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
  (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define READ_CS_CYC `CYC(`T_READ_CS_NS)
`define READ_SETUP_CYC `CYC(`T_READ_SETUP_NS)
`define WRITE_CS_CYC `CYC(`T_WRITE_CS_NS)
`define LOAD_LOW_CYC `CYC(`T_LOAD_LOW_NS)
`define BUS_RELEASE_CYC `CYC(`T_BUS_RELEASE_NS)
`define RESET_LOW_CYC `CYC(`T_RESET_LOW_NS)
`define CNT_WIDTH 8
`endif

// >>> hold_timer.v
// Purpose: down counter that times each pin phase
// Assumes: single clock domain
// Notes: done is high when count has reached zero
`timescale 1ns/1ns
module hold_timer #(
  parameter WIDTH = 8
) (
  input wire ref_clk,
  input wire rstn,
  input wire load,
  input wire [WIDTH-1:0] value,
  output wire done
);
  reg [WIDTH-1:0] count_q;
  reg [WIDTH-1:0] count_d;

  // Load wins over counting
  always @*
  begin
    count_d = count_q;
    if (load)
      count_d = value;
    else if (count_q != {WIDTH{1'b0}})
      count_d = count_q - {{(WIDTH-1){1'b0}}, 1'b1};
  end

  // Counter register
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      count_q <= {WIDTH{1'b0}};
    else
      count_q <= count_d;
  end

  assign done = (count_q == {WIDTH{1'b0}});
endmodule

// >>> quad_conv_host.v
// Purpose: host controller driving the quad converter parallel pins
// Assumes: one request at a time on cmd_valid; converter pins direct
// Notes: all pin outputs registered; data bus output enable is active low
// Function
// [RULE_01] The converter holds four channels, each with input and output latch.
// [RULE_02] Codes are 12-bit parallel words and input latches can be read back.
// [RULE_03] Reset forces every latch and output to the variant reset code.
// [RULE_04] Latches follow input while control is low and hold when it rises.
// [RULE_05] Only one input latch is open, and none while chip select is high.
// [RULE_06] Chip select low with read/write low writes, high reads the chosen latch.
// [RULE_07] Load low opens all output latches together; high holds them.
// [RULE_08] To update one channel, write its input latch then pulse load.
// [RULE_09] With load kept low each output follows its input latch write.
// [RULE_10] Input latches may be written with load high, then load low updates all.
// [RULE_11] After reset release holding latches keep the reset code.
// [RULE_12] Upper select picks C or D, lower select picks B or D.
// [RULE_13] The converter reset is asynchronous, active low and overrides all.
// [RULE_14] The converter drives the bus only during a read, then releases it.
// [RULE_15] Selects, read/write and data stay stable while chip select is low.
`timescale 1ns/1ns
`include "quad_conv_regs.vh"
module quad_conv_host #(
  parameter CODE_WIDTH = `CODE_WIDTH
) (
  input wire ref_clk,
  input wire rstn,
  // Command port
  input wire cmd_valid,
  input wire [1:0] cmd_op,
  input wire [1:0] cmd_chan,
  input wire [CODE_WIDTH-1:0] cmd_data,
  input wire load_transparent,
  output reg cmd_ready,
  output reg rsp_valid,
  output reg [CODE_WIDTH-1:0] rsp_data,
  // Converter pins
  output reg chip_select_n,
  output reg read_write,
  output reg channel_select_high,
  output reg channel_select_low,
  output reg load_outputs_n,
  output reg reset_n,
  output reg [CODE_WIDTH-1:0] data_bus_out,
  output reg data_bus_oe_n,
  input wire [CODE_WIDTH-1:0] data_bus_in
);
  // Command codes
  localparam [1:0] OP_WRITE = 2'b00;
  localparam [1:0] OP_READ = 2'b01;
  localparam [1:0] OP_LOAD = 2'b10;
  localparam [1:0] OP_RESET = 2'b11;
  // One-hot states
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_SETUP = 6'h02;
  localparam [5:0] S_ACCESS = 6'h04;
  localparam [5:0] S_RELEASE = 6'h08;
  localparam [5:0] S_LOAD = 6'h10;
  localparam [5:0] S_RESET = 6'h20;
  // Counts come out as 32-bit integers; cut to the timer width on purpose
  localparam integer READ_SETUP_I = `READ_SETUP_CYC;
  localparam integer READ_CS_I = `READ_CS_CYC;
  localparam integer WRITE_CS_I = `WRITE_CS_CYC;
  localparam integer LOAD_LOW_I = `LOAD_LOW_CYC;
  localparam integer BUS_REL_I = `BUS_RELEASE_CYC;
  localparam integer RESET_LOW_I = `RESET_LOW_CYC;
  localparam [`CNT_WIDTH-1:0] READ_SETUP = READ_SETUP_I[`CNT_WIDTH-1:0];
  localparam [`CNT_WIDTH-1:0] READ_CS = READ_CS_I[`CNT_WIDTH-1:0];
  localparam [`CNT_WIDTH-1:0] WRITE_CS = WRITE_CS_I[`CNT_WIDTH-1:0];
  localparam [`CNT_WIDTH-1:0] LOAD_LOW = LOAD_LOW_I[`CNT_WIDTH-1:0];
  localparam [`CNT_WIDTH-1:0] BUS_REL = BUS_REL_I[`CNT_WIDTH-1:0];
  localparam [`CNT_WIDTH-1:0] RESET_LOW = RESET_LOW_I[`CNT_WIDTH-1:0];

  reg [5:0] state_q;
  reg [5:0] state_d;
  reg is_read_q;
  reg timer_load;
  reg [`CNT_WIDTH-1:0] timer_value;
  wire timer_done;
  reg [CODE_WIDTH-1:0] bus_meta_q;
  reg [CODE_WIDTH-1:0] bus_sync_q;
  reg load_keep_meta_q;
  reg load_keep_q;

  // Phase timer
  hold_timer #(
    .WIDTH(`CNT_WIDTH)
  ) u_timer (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .load(timer_load),
    .value(timer_value),
    .done(timer_done)
  );

  // Read data from pins and level input pass two flops
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bus_meta_q <= {CODE_WIDTH{1'b0}};
      bus_sync_q <= {CODE_WIDTH{1'b0}};
      load_keep_meta_q <= 1'b0;
      load_keep_q <= 1'b0;
    end
    else
    begin
      bus_meta_q <= data_bus_in;
      bus_sync_q <= bus_meta_q;
      load_keep_meta_q <= load_transparent;
      load_keep_q <= load_keep_meta_q;
    end
  end

  // Next state and timer loading
  always @*
  begin
    state_d = state_q;
    timer_load = 1'b0;
    timer_value = {`CNT_WIDTH{1'b0}};
    case (state_q)
      S_IDLE:
      begin
        if (cmd_valid && cmd_ready)
        begin
          timer_load = 1'b1;
          case (cmd_op)
            OP_WRITE:
            begin
              state_d = S_SETUP;
              timer_value = LOAD_LOW; // Load low lead time before chip select
            end
            OP_READ:
            begin
              state_d = S_SETUP;
              timer_value = READ_SETUP;
            end
            OP_LOAD:
            begin
              state_d = S_LOAD;
              timer_value = LOAD_LOW;
            end
            default:
            begin
              state_d = S_RESET;
              timer_value = RESET_LOW;
            end
          endcase
        end
      end
      S_SETUP:
      begin
        if (timer_done)
        begin
          state_d = S_ACCESS;
          timer_load = 1'b1;
          // Read waits for valid data plus two sync stages
          timer_value = is_read_q ? READ_CS + 8'h02 : WRITE_CS;
        end
      end
      S_ACCESS:
      begin
        if (timer_done)
        begin
          state_d = S_RELEASE;
          timer_load = 1'b1;
          timer_value = BUS_REL; // [RULE_14]
        end
      end
      S_RELEASE, S_LOAD, S_RESET:
      begin
        if (timer_done)
          state_d = S_IDLE;
      end
      default:
        state_d = S_IDLE;
    endcase
  end

  // Pin and response registers
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= S_IDLE;
      is_read_q <= 1'b0;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= {CODE_WIDTH{1'b0}};
      chip_select_n <= 1'b1; // [RULE_05]
      read_write <= 1'b1;
      channel_select_high <= 1'b0;
      channel_select_low <= 1'b0;
      load_outputs_n <= 1'b1;
      reset_n <= 1'b0; // [RULE_13] Converter held in reset with host
      data_bus_out <= {CODE_WIDTH{1'b0}};
      data_bus_oe_n <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      rsp_valid <= 1'b0;
      reset_n <= 1'b1;
      cmd_ready <= (state_d == S_IDLE);
      // Transparent mode keeps output latches open [RULE_09]
      if (state_d == S_IDLE)
        load_outputs_n <= ~load_keep_q;
      case (state_q)
        S_IDLE:
        begin
          if (cmd_valid && cmd_ready)
          begin
            is_read_q <= (cmd_op == OP_READ);
            // Selects and data frozen until chip select rises [RULE_15] [RULE_12]
            channel_select_high <= cmd_chan[1];
            channel_select_low <= cmd_chan[0];
            read_write <= (cmd_op == OP_READ); // [RULE_06]
            if (cmd_op == OP_WRITE)
            begin
              data_bus_out <= cmd_data; // [RULE_02]
              data_bus_oe_n <= 1'b0;
            end
            if (cmd_op == OP_LOAD)
              load_outputs_n <= 1'b0; // [RULE_08] [RULE_10] [RULE_07]
            if (cmd_op == OP_RESET)
              reset_n <= 1'b0; // [RULE_03] [RULE_11]
          end
        end
        S_SETUP:
        begin
          if (timer_done)
            chip_select_n <= 1'b0; // [RULE_04] Latch opens on low level
        end
        S_ACCESS:
        begin
          if (timer_done)
          begin
            chip_select_n <= 1'b1; // Write word latched on this rise
            if (is_read_q)
            begin
              rsp_valid <= 1'b1;
              rsp_data <= bus_sync_q; // [RULE_02]
            end
          end
        end
        S_RELEASE:
        begin
          // Hold data and selects one phase past chip select high
          if (timer_done)
            data_bus_oe_n <= 1'b1;
        end
        S_LOAD:
        begin
          // Release on the exit edge, else a following write sees load low
          if (timer_done)
            load_outputs_n <= ~load_keep_q;
          else
            load_outputs_n <= 1'b0;
        end
        S_RESET:
          reset_n <= 1'b0;
        default:
          chip_select_n <= 1'b1;
      endcase
    end
  end
endmodule

// >>> quad_conv_checker.sv
// Purpose: pin protocol checks for the quad converter host
// Assumes: one clock, rstn asynchronous active low
// Notes: bound to every quad_conv_host instance
`timescale 1ns/1ns
module quad_conv_checker #(
  parameter CODE_WIDTH = 12
) (
  input logic ref_clk,
  input logic rstn,
  input logic cmd_valid,
  input logic cmd_ready,
  input logic [1:0] cmd_op,
  input logic [1:0] cmd_chan,
  input logic [CODE_WIDTH-1:0] cmd_data,
  input logic rsp_valid,
  input logic chip_select_n,
  input logic read_write,
  input logic channel_select_high,
  input logic channel_select_low,
  input logic load_outputs_n,
  input logic reset_n,
  input logic [CODE_WIDTH-1:0] data_bus_out,
  input logic data_bus_oe_n
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  logic [1:0] chan_q;
  logic [CODE_WIDTH-1:0] data_q;
  wire [1:0] sel = {channel_select_high, channel_select_low};
  // Channel and word of the last accepted command
  always @(posedge ref_clk)
    if (cmd_valid && cmd_ready)
    begin
      chan_q <= cmd_chan;
      data_q <= cmd_data;
    end
  sequence s_take(logic [1:0] op);
    cmd_valid && cmd_ready && cmd_op == op;
  endsequence
  sequence s_cs_fall(logic rd);
    $fell(chip_select_n) && read_write == rd;
  endsequence
  property p_write_pins;
    !chip_select_n && !read_write |-> sel == chan_q && data_bus_out == data_q && !data_bus_oe_n;
  endproperty
  a_write_pins: assert property (p_write_pins)
    else $error("write pins");
  property p_read_float;
    !chip_select_n && read_write |-> data_bus_oe_n;
  endproperty
  a_read_float: assert property (p_read_float)
    else $error("host drives during read");
  property p_stable;
    !chip_select_n && !$past(chip_select_n) |->
      $stable(read_write) && $stable(sel) && $stable(data_bus_out);
  endproperty
  a_stable: assert property (p_stable)
    else $error("pins moved under select");
  property p_read_len;
    s_cs_fall(1'b1) |-> !chip_select_n [*8] ##1 !chip_select_n [*2];
  endproperty
  a_read_len: assert property (p_read_len)
    else $error("read select short");
  property p_write_len;
    s_cs_fall(1'b0) |-> !chip_select_n [*3];
  endproperty
  a_write_len: assert property (p_write_len)
    else $error("write select short");
  property p_read_rsp;
    s_take(2'b01) |-> ##[1:30] rsp_valid;
  endproperty
  a_read_rsp: assert property (p_read_rsp)
    else $error("no read answer");
  property p_load;
    s_take(2'b10) |-> ##[1:8] !load_outputs_n [*3];
  endproperty
  a_load: assert property (p_load)
    else $error("load pulse");
  property p_reset;
    s_take(2'b11) |-> ##[1:8] !reset_n [*3];
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset pulse");
endmodule
bind quad_conv_host quad_conv_checker #(.CODE_WIDTH(CODE_WIDTH)) u_chk (.*);

// >>> quad_conv_model.sv
// Purpose: behavioural quad converter latch bank
// Assumes: pins driven by the host controller
// Notes: no clock; reset code is a parameter
`timescale 1ns/1ns
module quad_conv_model #(
  parameter [11:0] RESET_CODE = 12'h800
) (
  input wire chip_select_n,
  input wire read_write,
  input wire channel_select_high,
  input wire channel_select_low,
  input wire load_outputs_n,
  input wire reset_n,
  input wire [11:0] data_bus_in,
  output wire [11:0] model_data,
  output wire model_drive,
  output wire [47:0] dac_code
);
  logic [11:0] in_q [4];
  logic [11:0] out_q [4];
  wire [1:0] sel = {channel_select_high, channel_select_low};
  // Input latches: reset wins, else only the selected one follows
  always_latch
    if (!reset_n)
      in_q <= '{4{RESET_CODE}};
    else if (!chip_select_n && !read_write)
      in_q[sel] <= data_bus_in;
  // Output latches all open while load is low
  always_latch
    if (!reset_n)
      out_q <= '{4{RESET_CODE}};
    else if (!load_outputs_n)
      out_q <= in_q;
  // Readback drives only while a read is selected
  assign model_drive = reset_n && !chip_select_n && read_write;
  assign model_data = in_q[sel];
  assign dac_code = {out_q[3], out_q[2], out_q[1], out_q[0]};
endmodule

// >>> test_quad_conv_host.sv
// Purpose: self-checking bench for quad_conv_host
// Assumes: 50 MHz ref_clk, converter model on the pins
// Notes: read answers are scored from a queue of notes
`timescale 1ns/1ns
module test_quad_conv_host;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_op = 2'b00;
  logic [1:0] cmd_chan = 2'b00;
  logic [11:0] cmd_data = 12'h000;
  logic load_transparent = 1'b0;
  wire cmd_ready, rsp_valid, chip_select_n, read_write, channel_select_high;
  wire channel_select_low, load_outputs_n, reset_n, data_bus_oe_n, model_drive;
  wire [11:0] rsp_data, data_bus_out, data_bus_in, model_data;
  wire [47:0] dac_code;
  logic [11:0] bus_last = 12'h000;
  logic [11:0] w [4];
  logic [11:0] exp_q [$];
  int num_errors = 0;
  int n_checks = 0;
  int seed = 32'h5d40;
  quad_conv_host i_dut (.*);
  quad_conv_model #(.RESET_CODE(12'h800)) i_conv (.*);
  always #10 ref_clk = ~ref_clk;
  // Released bus keeps changing so a stale word cannot pass
  assign data_bus_in = !data_bus_oe_n ? data_bus_out : model_drive ? model_data : ~bus_last;
  always @(posedge ref_clk) bus_last <= data_bus_in;
  task automatic check(input logic [47:0] seen, input logic [47:0] want);
    n_checks++;
    if (seen !== want)
    begin
      num_errors++;
      $display("mismatch at %0t: %h vs %h", $time, seen, want);
    end
  endtask
  task automatic close_out;
    if (num_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
    end
    while (cmd_ready !== 1'b1 && n < 300);
    if (n >= 300)
    begin
      num_errors++;
      close_out();
    end
  endtask
  task automatic send(input logic [1:0] op, input logic [1:0] ch, input logic [11:0] d);
    wait_ready();
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_chan <= ch;
    cmd_data <= d;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] ch, input logic [11:0] e);
    exp_q.push_back(e);
    send(2'b01, ch, 12'h000);
  endtask
  // Each read answer is scored against the oldest note
  always @(posedge ref_clk)
    if (rsp_valid === 1'b1)
      check(rsp_data, exp_q.size() ? exp_q.pop_front() : 12'hxxx);
  initial
  begin
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int c = 0; c < 4; c++)
      rd(c[1:0], 12'h800);
    wait_ready();
    check(dac_code, {4{12'h800}});
    // Writes with load high must not reach the outputs
    for (int c = 0; c < 4; c++)
    begin
      w[c] = 12'($random(seed));
      send(2'b00, c[1:0], w[c]);
    end
    wait_ready();
    check(dac_code, {4{12'h800}});
    for (int c = 0; c < 4; c++)
      rd(c[1:0], w[c]);
    send(2'b10, 2'b00, 12'h000);
    wait_ready();
    check(dac_code, {w[3], w[2], w[1], w[0]});
    // Write right after a load pulse must wait for the next pulse
    send(2'b00, 2'b01, ~w[1]);
    wait_ready();
    check(dac_code, {w[3], w[2], w[1], w[0]});
    w[1] = ~w[1];
    // Transparent load: a write reaches its output unpulsed
    @(posedge ref_clk);
    load_transparent <= 1'b1;
    repeat (4) @(posedge ref_clk);
    w[2] = 12'($random(seed));
    send(2'b00, 2'b10, w[2]);
    wait_ready();
    check(dac_code, {w[3], w[2], w[1], w[0]});
    @(posedge ref_clk);
    load_transparent <= 1'b0;
    send(2'b11, 2'b00, 12'h000);
    wait_ready();
    check(dac_code, {4{12'h800}});
    rd(2'b11, 12'h800);
    wait_ready();
    check(48'(exp_q.size()), 48'h0);
    close_out();
  end
endmodule
